// ---- rtl/tsr_pkg.sv ----
package tsr_pkg;

	// ==========================================================
	// report widths
	localparam int LCW_W   = 16;
	localparam int PULSE_W = 16;
	localparam int AUTH_W  = 80;
	localparam int FSR_W  = 32;
	localparam int SH_W   = 80;
	localparam int NCHAN  = 6;

	// ==========================================================
	// report select codes on the telemetry select pins
	localparam logic [1:0] SEL_LCW   = 2'h0;
	localparam logic [1:0] SEL_PULSE = 2'h1;
	localparam logic [1:0] SEL_AUTH  = 2'h2;
	localparam logic [1:0] SEL_FSR  = 2'h3;

	// ==========================================================
	// pin synchroniser layout: rf, channels, au start, load, shift, select
	localparam int PIN_W    = 12;
	localparam int PIN_RF   = 0;
	localparam int PIN_CH   = 1;
	localparam int PIN_XSTART = 7;
	localparam int PIN_LOAD = 8;
	localparam int PIN_SCLK = 9;
	localparam int PIN_SEL  = 10;

	// ==========================================================
	// link control word fields
	localparam logic       LCW_REPORT_TYPE  = 1'h0;
	localparam logic [1:0] BCNT_RESET       = 2'h0;

	// ==========================================================
	// command pulse status
	localparam logic [1:0]  PULSE_COLD     = 2'h0;
	localparam logic [1:0]  PULSE_LEGAL    = 2'h1;
	localparam logic [1:0]  PULSE_ILLEGAL  = 2'h2;
	localparam logic [1:0]  PULSE_DIRTY    = 2'h3;
	localparam logic [13:0] PULSE_SEQ_COLD = 14'h3fff;
	localparam logic [15:0] PULSE_RESET    = {PULSE_COLD, PULSE_SEQ_COLD};

	// ==========================================================
	// authentication status fixed fields
	localparam logic [1:0]  AUTH_PRI_TAG = 2'h0;
	localparam logic [1:0]  AUTH_AUX_TAG = 2'h1;
	localparam logic [6:0]  AUTH_RSVD    = 7'h00;
	localparam logic [79:0] AUTH_RESET   = 80'h0000_0000_4000_0000_0000;

	// ==========================================================
	// frame survey outcome codes, lowest wins
	localparam logic [2:0] FA_ABANDONED = 3'h0;
	localparam logic [2:0] FA_DIRTY     = 3'h1;
	localparam logic [2:0] FA_ILL_ONE   = 3'h2;
	localparam logic [2:0] FA_ILL_MANY  = 3'h3;
	localparam logic [2:0] FA_LOCKOUT   = 3'h4;
	localparam logic [2:0] FA_WAIT      = 3'h5;
	localparam logic [2:0] FA_SEQ       = 3'h6;
	localparam logic [2:0] FA_ACCEPTED  = 3'h7;
	localparam logic [2:0] FQ_NONE      = 3'h0;
	localparam logic [1:0] LFQ_NOREPORT = 2'h1;
	localparam logic [24:0] FSR_TAIL_COLD = 25'h00f_fff0 | 25'h0010000;
	// bits 17 and 18-26 set, everything else clear
	localparam logic [31:0] FSR_RESET   = 32'h0000_7fe0;
	localparam logic        FSR_NEW     = 1'h0;
	localparam logic        FSR_OLD     = 1'h1;

endpackage

// ---- rtl/tsr_reports.sv ----
// Contract
// - each report is held double buffered; a readout never sees a change
// - only the two low octets of the link control word are produced
// - no-rf bit follows the rf_unavailable_in pin level
// - no-bit-lock bit is 1 when all six channel inputs are low
// - lockout and wait flags follow the frame acceptance machine state
// - retransmit flag set when an AD frame was lost or discarded
// - two-bit B counter wraps modulo 4 on each valid BC/BD frame
// - report type bit always reads zero
// - report value carries next expected sequence number V(R)
// - every report shifts out serially, bit 0 (MSB) first
// - pulse status bits 0-1 give cold/legal/not legal/not clean
// - pulse status bits 2-15 all ones at cold start, else last sequence
// - auth status 80 bits; bits 0-1 are 00, then principal counter
// - bits 32-33 are 01, then auxiliary counter ending at bit 63
// - bit 64 shows key in use; bits 65-71 read zero
// - bits 72-79 hold eight low bits of recovery counter
// - auth double buffer lives in external memory; select pin names current
// - auth buffer toggling frozen while external_au_start is high
// - survey bit 0 is 0 for new or cold data, 1 once old
// - survey codes 000 to 011: abandoned, dirty, illegal one, illegal many
// - survey codes 100 to 111: lockout, wait, sequence mismatch, accepted
// - with several outcomes the lowest code is reported
// - for several illegal reasons the lowest reason code is reported
// - abandoned unit forces qualifier 000 and legal frame qualifier 01
module tsr_reports (
	// clock and reset
	input  wire logic                mclk,
	input  wire logic                reset,
	// pins from outside the clock domain
	input  wire logic                rf_unavailable_in,
	input  wire logic [5:0]          channel_active_in,
	input  wire logic                external_au_start,
	input  wire logic                tm_load_in,
	input  wire logic                tm_shift_in,
	input  wire logic [1:0]          tm_select_in,
	// frame acceptance machine
	input  wire logic                farm_lockout,
	input  wire logic                farm_wait,
	input  wire logic                farm_retransmit,
	input  wire logic                farm_bcbd_valid,
	input  wire logic [7:0]          farm_next_seq,
	// command pulse unit
	input  wire logic                cpu_done,
	input  wire logic [1:0]          cpu_result,
	input  wire logic [13:0]         cpu_seq_count,
	// authentication unit
	input  wire logic                au_update,
	input  wire logic [29:0]         au_principal_count,
	input  wire logic [29:0]         au_auxiliary_count,
	input  wire logic                au_key_programmable,
	input  wire logic [7:0]          au_recovery_count,
	// frame analysis
	input  wire logic                fa_event,
	input  wire logic                fa_abandoned,
	input  wire logic                fa_dirty,
	input  wire logic [7:1]          fa_illegal_reasons,
	input  wire logic                fa_lockout,
	input  wire logic                fa_wait,
	input  wire logic                fa_seq_mismatch,
	input  wire logic                fa_accepted,
	input  wire logic [24:0]         fa_tail,
	// report outputs
	output logic [15:0]              link_control_word_low,
	output logic [15:0]              command_pulse_status,
	output logic [79:0]              authentication_status,
	output logic [31:0]              frame_survey_report,
	output logic                     authentication_status_buffer_select,
	output logic                     tm_data_out
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [11:0] pin_s1;
		logic [11:0] pin_s2;
		logic        load_d;
		logic        sclk_d;
		logic [1:0]  bcnt;
		logic [15:0] lcw;
		logic [15:0] pulse;
		logic [79:0] auth;
		logic [31:0] fsr;
		logic        au_sel;
		logic [79:0] sh;
		logic        tdo;
	} tsr_state_s;

	tsr_state_s st_r;
	tsr_state_s st_nxt;

	// ==========================================================
	// per-bit reason scan, lowest set code wins
	logic [2:0] ill_code;
	logic [2:0] ill_cnt;
	logic [7:1] ill_lower;

	genvar gi;
	generate
		for (gi = 1; gi <= 7; gi++) begin : g_ill
			if (gi == 1) begin : g_first
				assign ill_lower[gi] = 1'b0;
			end else begin : g_rest
				assign ill_lower[gi] = |fa_illegal_reasons[gi-1:1];
			end
		end
	endgenerate

	always_comb begin
		ill_code = tsr_pkg::FQ_NONE;
		ill_cnt  = 3'h0;
		for (int i = 7; i >= 1; i--) begin
			if (fa_illegal_reasons[i] && !ill_lower[i]) begin
				ill_code = 3'(i);
			end
			ill_cnt = ill_cnt + {2'h0, fa_illegal_reasons[i]};
		end
	end

	// ==========================================================
	// next state
	logic [2:0]  fa_code;
	logic [2:0]  fa_qual;
	logic [24:0] fa_tail_q;
	logic        load_rise;
	logic        sclk_rise;
	logic        xstart_s;

	always_comb begin
		st_nxt = st_r;

		// pins cross in through two flops
		st_nxt.pin_s1 = {tm_select_in, tm_shift_in, tm_load_in, external_au_start,
		                 channel_active_in, rf_unavailable_in};
		st_nxt.pin_s2 = st_r.pin_s1;
		st_nxt.load_d = st_r.pin_s2[tsr_pkg::PIN_LOAD];
		st_nxt.sclk_d = st_r.pin_s2[tsr_pkg::PIN_SCLK];
		load_rise = st_r.pin_s2[tsr_pkg::PIN_LOAD] && !st_r.load_d;
		sclk_rise = st_r.pin_s2[tsr_pkg::PIN_SCLK] && !st_r.sclk_d;
		xstart_s  = st_r.pin_s2[tsr_pkg::PIN_XSTART];

		// link control word, rebuilt every cycle into the live buffer
		if (farm_bcbd_valid) begin
			st_nxt.bcnt = st_r.bcnt + 2'h1;
		end
		st_nxt.lcw = {
			st_r.pin_s2[tsr_pkg::PIN_RF],
			~|st_r.pin_s2[tsr_pkg::PIN_CH +: tsr_pkg::NCHAN],
			farm_lockout,
			farm_wait,
			farm_retransmit,
			st_r.bcnt,
			tsr_pkg::LCW_REPORT_TYPE,
			farm_next_seq
		};

		// command pulse status keeps the last legal sequence count
		if (cpu_done) begin
			st_nxt.pulse[15:14] = cpu_result;
			if (cpu_result == tsr_pkg::PULSE_LEGAL) begin
				st_nxt.pulse[13:0] = cpu_seq_count;
			end
		end

		// authentication status; internal unit fills the live copy
		if (au_update) begin
			st_nxt.auth = {tsr_pkg::AUTH_PRI_TAG, au_principal_count,
			               tsr_pkg::AUTH_AUX_TAG, au_auxiliary_count,
			               au_key_programmable, tsr_pkg::AUTH_RSVD,
			               au_recovery_count};
			// external memory buffer flips only when no external unit is running
			if (!xstart_s) begin
				st_nxt.au_sel = ~st_r.au_sel;
			end
		end

		// frame survey: lowest outcome code wins
		fa_qual   = ill_code;
		fa_tail_q = fa_tail;
		if (fa_abandoned) begin
			fa_code = tsr_pkg::FA_ABANDONED;
			fa_qual = tsr_pkg::FQ_NONE;
			fa_tail_q[24:23] = 2'h0;
			fa_tail_q[15:14] = tsr_pkg::LFQ_NOREPORT;
		end else if (fa_dirty) begin
			fa_code = tsr_pkg::FA_DIRTY;
		end else if (ill_cnt > 3'h1) begin
			fa_code = tsr_pkg::FA_ILL_MANY;
		end else if (ill_cnt == 3'h1) begin
			fa_code = tsr_pkg::FA_ILL_ONE;
		end else if (fa_lockout) begin
			fa_code = tsr_pkg::FA_LOCKOUT;
		end else if (fa_wait) begin
			fa_code = tsr_pkg::FA_WAIT;
		end else if (fa_seq_mismatch) begin
			fa_code = tsr_pkg::FA_SEQ;
		end else begin
			fa_code = tsr_pkg::FA_ACCEPTED;
		end

		// ======================================================
		// readout: a snapshot is taken so later updates cannot tear it
		if (load_rise) begin
			unique case (st_r.pin_s2[tsr_pkg::PIN_SEL +: 2])
				tsr_pkg::SEL_LCW:   st_nxt.sh = {st_r.lcw, 64'h0};
				tsr_pkg::SEL_PULSE: st_nxt.sh = {st_r.pulse, 64'h0};
				tsr_pkg::SEL_AUTH:  st_nxt.sh = st_r.auth;
				tsr_pkg::SEL_FSR:  st_nxt.sh = {st_r.fsr, 48'h0};
			endcase
			st_nxt.tdo = st_nxt.sh[79];
			// reading the survey ages it
			if (st_r.pin_s2[tsr_pkg::PIN_SEL +: 2] == tsr_pkg::SEL_FSR) begin
				st_nxt.fsr[31] = tsr_pkg::FSR_OLD;
			end
		end else if (sclk_rise) begin
			st_nxt.sh  = {st_r.sh[78:0], 1'b0};
			st_nxt.tdo = st_r.sh[78];
		end

		// new survey data wins over the ageing read in the same cycle
		if (fa_event) begin
			st_nxt.fsr = {tsr_pkg::FSR_NEW, fa_code, fa_qual, fa_tail_q};
		end

		if (reset) begin
			st_nxt        = '0;
			st_nxt.bcnt   = tsr_pkg::BCNT_RESET;
			st_nxt.pulse  = tsr_pkg::PULSE_RESET;
			st_nxt.auth   = tsr_pkg::AUTH_RESET;
			st_nxt.fsr    = tsr_pkg::FSR_RESET;
		end
	end

	always_ff @(posedge mclk) begin
		st_r <= st_nxt;
	end

	// ==========================================================
	// outputs
	assign link_control_word_low   = st_r.lcw;
	assign command_pulse_status    = st_r.pulse;
	assign authentication_status   = st_r.auth;
	assign frame_survey_report     = st_r.fsr;
	assign authentication_status_buffer_select = st_r.au_sel;
	assign tm_data_out             = st_r.tdo;

endmodule

// ---- tb/tsr_reports_monitor.sv ----
module tsr_monitor (
	// clock, reset and producers
	input wire logic        mclk,
	input wire logic        reset,
	input wire logic        farm_lockout,
	input wire logic        farm_wait,
	input wire logic        farm_retransmit,
	input wire logic [7:0]  farm_next_seq,
	input wire logic        cpu_done,
	input wire logic [1:0]  cpu_result,
	input wire logic [13:0] cpu_seq_count,
	input wire logic        au_update,
	input wire logic [29:0] au_principal_count,
	input wire logic [29:0] au_auxiliary_count,
	input wire logic        au_key_programmable,
	input wire logic [7:0]  au_recovery_count,
	input wire logic        fa_event,
	// reports
	input wire logic [15:0] link_control_word_low,
	input wire logic [15:0] command_pulse_status,
	input wire logic [79:0] authentication_status,
	input wire logic [31:0] frame_survey_report,
	input wire logic        authentication_status_buffer_select
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// ==========================================================
	// report contents; link word lags its farm inputs by one edge
	property p_rtype; link_control_word_low[8] == 1'h0; endproperty
	a_rtype: assert property (p_rtype) else $error("report type set");
	property p_flags; !$past(reset) |-> link_control_word_low[13:12] ==
		{$past(farm_lockout), $past(farm_wait)}; endproperty
	a_flags: assert property (p_flags) else $error("farm flags wrong");
	property p_vr; !$past(reset) |-> link_control_word_low[11] == $past(farm_retransmit)
		&& link_control_word_low[7:0] == $past(farm_next_seq); endproperty
	a_vr: assert property (p_vr) else $error("retransmit or value wrong");
	property p_cpu_ok; cpu_done && cpu_result == 2'h1 |=>
		command_pulse_status == {2'h1, $past(cpu_seq_count)}; endproperty
	a_cpu_ok: assert property (p_cpu_ok) else $error("legal status wrong");
	property p_cpu_bad; cpu_done && cpu_result[1] |=> command_pulse_status ==
		{$past(cpu_result), $past(command_pulse_status[13:0])}; endproperty
	a_cpu_bad: assert property (p_cpu_bad) else $error("erased status wrong");
	property p_auth; au_update |=> authentication_status == {2'h0, $past(au_principal_count),
		2'h1, $past(au_auxiliary_count), $past(au_key_programmable), 7'h00,
		$past(au_recovery_count)}; endproperty
	a_auth: assert property (p_auth) else $error("auth status wrong");
	property p_sel; !$past(reset) && !$stable(authentication_status_buffer_select) |-> $past(au_update);
	endproperty
	a_sel: assert property (p_sel) else $error("select moved alone");
	property p_new; fa_event |=> frame_survey_report[31] == 1'h0; endproperty
	a_new: assert property (p_new) else $error("survey not new");
	c_legal: cover property (cpu_done && cpu_result == 2'h1);
	c_auth: cover property (au_update);
	c_fsr: cover property (fa_event);
endmodule

bind tsr_reports tsr_monitor u_tsr_monitor (.*);

// ---- tb/tsr_reports_tb.sv ----
module tsr_reports_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        mclk, reset, rf_unavailable_in, external_au_start, tm_load_in, tm_shift_in;
	logic        farm_lockout, farm_wait, farm_retransmit, farm_bcbd_valid, cpu_done, sb;
	logic        au_update, au_key_programmable, fa_event, fa_abandoned, fa_dirty, fa_wait;
	logic        fa_lockout, fa_seq_mismatch, fa_accepted, authentication_status_buffer_select, tm_data_out;
	logic [1:0]  tm_select_in, cpu_result, bcnt;
	logic [5:0]  channel_active_in;
	logic [7:1]  fa_illegal_reasons;
	logic [7:0]  farm_next_seq, au_recovery_count;
	logic [13:0] cpu_seq_count;
	logic [15:0] link_control_word_low, command_pulse_status, rnd;
	logic [24:0] fa_tail;
	logic [29:0] au_principal_count, au_auxiliary_count;
	logic [31:0] frame_survey_report;
	logic [79:0] authentication_status, w, e;
	int          n_fail, compares;
	tsr_reports u_tsr_reports (.*);
	tsr_tm_reader u_tsr_tm_reader (.*);
	// ==========================================================
	// helpers
	task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		$display("mismatches %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [15:0] lcw_exp(input logic [1:0] b);
		return {rf_unavailable_in, ~|channel_active_in, farm_lockout, farm_wait,
			farm_retransmit, b, 1'h0, farm_next_seq};
	endfunction
	initial begin
		mclk = 1'h0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		results();
	end
	initial begin
		{n_fail, compares, rnd, reset, bcnt} = {32'h0, 32'h0, 16'h0057, 1'h1, 2'h0};
		{rf_unavailable_in, external_au_start, farm_lockout, farm_wait, farm_retransmit} = '0;
		{farm_bcbd_valid, cpu_done, cpu_result, cpu_seq_count, au_update, fa_event} = '0;
		{au_principal_count, au_auxiliary_count, au_key_programmable, au_recovery_count} = '0;
		{fa_abandoned, fa_dirty, fa_illegal_reasons, fa_lockout, fa_wait} = '0;
		{fa_seq_mismatch, fa_accepted, fa_tail, farm_next_seq, channel_active_in} = '0;
		repeat (20) @(posedge mclk);
		reset <= 1'h0;
		@(posedge mclk);
		u_tsr_tm_reader.read(tsr_pkg::SEL_PULSE, 16, 3, w);
		check("cold pulse", w, 80'h3fff);
		u_tsr_tm_reader.read(tsr_pkg::SEL_AUTH, 80, 3, w);
		check("cold auth", 80'({w[79:78], w[47:46], w[14:8]}), 80'h080);
		u_tsr_tm_reader.read(tsr_pkg::SEL_FSR, 32, 3, w);
		check("cold survey", 80'({w[31:25], w[15:14]}), 80'h001);
		check("old survey", 80'(frame_survey_report[31]), 80'h1);
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			{rf_unavailable_in, farm_lockout, farm_wait, farm_retransmit} <= rnd[3:0];
			channel_active_in <= (i == 0) ? 6'h00 : (i == 1) ? 6'h20 : rnd[9:4];
			farm_next_seq <= rnd[15:8];
			farm_bcbd_valid <= 1'h1;
			repeat (i + 1) @(posedge mclk);
			farm_bcbd_valid <= 1'h0;
			bcnt = bcnt + 2'(i + 1);
			repeat (4) @(posedge mclk);
			u_tsr_tm_reader.read(tsr_pkg::SEL_LCW, 16, 3, w);
			check("link word", w, 80'(lcw_exp(bcnt)));
		end
		{cpu_seq_count, cpu_result, cpu_done} <= {rnd[13:0], 2'h1, 1'h1};
		@(posedge mclk);
		cpu_done <= 1'h0;
		@(posedge mclk);
		fork
			u_tsr_tm_reader.read(tsr_pkg::SEL_PULSE, 16, 3, w);
			begin
				repeat (40) @(posedge mclk);
				{cpu_result, cpu_done} <= {2'h3, 1'h1};
				@(posedge mclk);
				cpu_done <= 1'h0;
			end
		join
		check("held pulse", w, 80'({2'h1, cpu_seq_count}));
		check("dirty pulse", 80'(command_pulse_status), 80'({2'h3, cpu_seq_count}));
		for (int k = 0; k < 2; k++) begin
			rnd = lfsr(rnd);
			external_au_start <= k[0];
			{au_principal_count, au_auxiliary_count} <= {rnd, ~rnd[13:0], ~rnd, rnd[13:0]};
			{au_key_programmable, au_recovery_count} <= rnd[8:0];
			repeat (4) @(posedge mclk);
			sb = authentication_status_buffer_select;
			e = {2'h0, au_principal_count, 2'h1, au_auxiliary_count, au_key_programmable,
				7'h00, au_recovery_count};
			au_update <= 1'h1;
			@(posedge mclk);
			au_update <= 1'h0;
			@(posedge mclk);
			check("auth select", 80'(authentication_status_buffer_select), 80'(sb ^ (k == 0)));
			u_tsr_tm_reader.read(tsr_pkg::SEL_AUTH, 80, 3 + 3 * k, w);
			check("auth", w, e);
		end
		external_au_start <= 1'h0;
		// every lower code also raises all higher ones bar one of the two illegal codes, so priority is exercised
		for (int c = 0; c < 8; c++) begin
			fa_illegal_reasons <= (c > 3) ? 7'h00 : (c == 2) ? 7'h40 : 7'h14;
			{fa_abandoned, fa_dirty, fa_event} <= {c == 0, c <= 1, 1'h1};
			{fa_lockout, fa_wait, fa_seq_mismatch, fa_accepted} <= {c <= 4, c <= 5, c <= 6, 1'h1};
			@(posedge mclk);
			fa_event <= 1'h0;
			@(posedge mclk);
			u_tsr_tm_reader.read(tsr_pkg::SEL_FSR, 32, 3, w);
			check("survey code", 80'(w[31:28]), 80'(c));
			if (c != 1 && c < 4)
				check("qualifier", 80'(w[27:25]), 80'((c == 2) ? 7 : (c == 3) ? 3 : 0));
			if (c == 0)
				check("no frame report", 80'(w[15:14]), 80'h1);
		end
		results();
	end
endmodule

// ---- tb/tsr_tm_reader.sv ----
module tsr_tm_reader (
	// telemetry pins
	input  wire logic mclk,
	input  wire logic tm_data_out,
	output logic      tm_load_in,
	output logic      tm_shift_in,
	output logic [1:0] tm_select_in
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		{tm_load_in, tm_shift_in, tm_select_in} = '0;
	end
	// high level held h edges, low level h+2, h of 1 or more, or the pin sync may miss it
	task automatic read(input logic [1:0] sel, input int n, input int h, output logic [79:0] w);
		w = '0;
		tm_select_in <= sel;
		for (int i = 0; i < n; i++) begin
			tm_load_in <= (i == 0);
			tm_shift_in <= (i != 0);
			repeat (h) @(posedge mclk);
			tm_load_in <= 1'h0;
			tm_shift_in <= 1'h0;
			repeat (h + 2) @(posedge mclk);
			w = {w[78:0], tm_data_out};
		end
		// select is idle between reads, so show it moving
		tm_select_in <= ~sel;
	endtask
endmodule
